/* File: rtl/apf_angle_postprocess.sv */
// Angle range extension, table linearization and field-lost monitor.
module apf_angle_postprocess #(
  parameter int ITER = apf_pkg::APF_CORDIC_ITER
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic meas_valid_in,
  input wire apf_pkg::apf_meas_t meas_in,
  input wire apf_pkg::apf_reg_req_t reg_req_in,
  output logic [15:0] reg_rdata_out,
  input wire logic nvm_wr_in,
  input wire logic [7:0] nvm_addr_in,
  input wire logic [15:0] nvm_wdata_in,
  output logic busy_out,
  output logic meas_done_out,
  output logic field_lost_flag_out,
  output logic [15:0] linearized_angle_out
);
  import apf_pkg::*;

  // Elaboration check on the CORDIC step count.
  if (ITER < 1 || ITER > 16) begin : g_bad_iter
    $error("apf_angle_postprocess: ITER must lie in 1..16");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_CORDIC, ST_LIN} apf_state_t;

  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;
  apf_state_t st_r;
  logic [15:0] ctrl_r;
  logic [15:0] cfg_r;
  logic [15:0] tbl_r [APF_TBL_N];
  apf_meas_t meas_r;
  logic [15:0] raw_r;
  logic [15:0] mag_r;
  logic [15:0] lin_r;
  logic lost_r;
  logic done_r;
  logic [15:0] rdata_r;
  logic start;
  logic signed [16:0] comp_first;
  logic signed [16:0] comp_second;
  logic cordic_done;
  logic [15:0] cordic_angle;
  logic [15:0] cordic_mag;
  logic ext_on;
  logic grad_on;
  logic outer;
  logic [15:0] raw_nxt;
  logic [7:0] lost_lmt;
  logic [2:0] lost_hyst;
  logic [14:0] clear_level;
  logic [6:0] nvm_sel;
  logic [4:0] seg;
  logic [10:0] frac;
  logic [15:0] lin_nxt;

  // Reset is released through two flops; the first is read only here.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // Factory table entry: output equals the base point input code.
  function automatic logic [15:0] factory_point(input int k);
    factory_point = 16'((k - 16) * APF_TBL_STEP);
  endfunction

  // Table index 0..32 (meaning -16..+16) for a non-volatile word address.
  function automatic logic [6:0] nvm_slot(input logic [7:0] a);
    if (a == APF_NVM_TOP) begin
      nvm_slot = {1'b1, 6'd32};
    end else if (a >= APF_NVM_POS && a < APF_NVM_NEG) begin
      nvm_slot = {1'b1, 6'(a - APF_NVM_POS + 8'd16)};
    end else if (a >= APF_NVM_NEG && a <= APF_NVM_END) begin
      nvm_slot = {1'b1, 6'(a - APF_NVM_NEG)};
    end else begin
      nvm_slot = 7'd0;
    end
  endfunction

  // Absolute value of a 17-bit signed component.
  function automatic logic [16:0] abs17(input logic signed [16:0] v);
    abs17 = v[16] ? 17'(-v) : 17'(v);
  endfunction

  // Control and field-lost configuration, written over the port.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= APF_CTRL_RESET;
      cfg_r <= APF_CFG_RESET;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.addr == APF_OFF_CTRL) begin
        ctrl_r <= reg_req_in.wdata & APF_CTRL_MASK;
      end
      if (reg_req_in.addr == APF_OFF_CFG) begin
        cfg_r <= reg_req_in.wdata & APF_CFG_MASK;
      end
    end
  end

  assign ext_on = ctrl_r[APF_CTRL_EXT_BIT];
  assign grad_on = ctrl_r[APF_CTRL_GRAD_BIT];
  assign lost_lmt = cfg_r[7:0];
  assign lost_hyst = cfg_r[10:8];
  assign nvm_sel = nvm_slot(nvm_addr_in);

  // The table models the non-volatile copy; reset reloads the factory set.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < APF_TBL_N; k++) begin
        tbl_r[k] <= factory_point(k);
      end
    end else if (nvm_wr_in && nvm_sel[6]) begin
      tbl_r[nvm_sel[5:0]] <= nvm_wdata_in;
    end
  end

  // Gradient mode builds each component from two pixels.
  always_comb begin
    if (grad_on) begin
      comp_first = 17'(meas_in.bi1) - 17'(meas_in.bi0);
      comp_second = 17'(meas_in.bj1) - 17'(meas_in.bj0);
    end else begin
      comp_first = 17'(meas_in.bi0);
      comp_second = 17'(meas_in.bj0);
    end
  end

  // A measurement offered while busy is dropped, not queued.
  assign start = meas_valid_in && (st_r == ST_IDLE);

  apf_cordic #(
    .ITER(ITER)
  ) u_cordic (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .start_in(start),
    .x_in(comp_first),
    .y_in(comp_second),
    .done_out(cordic_done),
    .angle_out(cordic_angle),
    .magnitude_out(cordic_mag)
  );

  // Sequencer: idle, CORDIC running, one linearization cycle.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (start) begin
            st_r <= ST_CORDIC;
          end
        end
        ST_CORDIC: begin
          if (cordic_done) begin
            st_r <= ST_LIN;
          end
        end
        ST_LIN: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Pixel values kept for the side decision of range extension.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      meas_r <= '0;
    end else if (start) begin
      meas_r <= meas_in;
    end
  end

  // Outer side: the far pixel sees more absolute field than the near one.
  // A strong homogeneous offset field can flip this decision.
  assign outer = abs17(17'(meas_r.bi1)) > abs17(17'(meas_r.bi0));

  // Unwrap past the half turn, then scale -288..+288 degrees to full code range.
  always_comb begin
    logic signed [17:0] unwrapped;
    logic signed [20:0] scaled;
    unwrapped = 18'(signed'(cordic_angle));
    scaled = '0;
    if (ext_on && grad_on) begin
      if (outer && cordic_angle[15]) begin
        unwrapped = unwrapped + 18'sd65536;
      end else if (outer && !cordic_angle[15]) begin
        unwrapped = unwrapped - 18'sd65536;
      end
      scaled = (21'(unwrapped) * 21'sd5) >>> 3;
      if (scaled > 21'sd32767) begin
        raw_nxt = 16'h7fff;
      end else if (scaled < -21'sd32768) begin
        raw_nxt = 16'h8000;
      end else begin
        raw_nxt = scaled[15:0];
      end
    end else begin
      raw_nxt = cordic_angle;
    end
  end

  // Raw angle and magnitude results, updated once per measurement.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      raw_r <= '0;
      mag_r <= '0;
    end else if (cordic_done) begin
      raw_r <= raw_nxt;
      mag_r <= cordic_mag;
    end
  end

  // Release level in full magnitude codes; one bit wider so it cannot wrap.
  assign clear_level = 15'({lost_lmt, 6'd0}) +
                       15'((12'(lost_lmt) << 4) >> lost_hyst);

  // Field-lost flag with hysteresis; compared at each measurement.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lost_r <= 1'b0;
    end else if (cordic_done) begin
      if (cordic_mag[13:6] < lost_lmt) begin
        lost_r <= 1'b1;
      end else if (cordic_mag[13:0] > clear_level || |cordic_mag[15:14]) begin
        lost_r <= 1'b0;
      end
    end
  end

  // Segment index and fraction; the table covers whatever span raw has.
  assign seg = {~raw_r[15], raw_r[14:11]};
  assign frac = raw_r[10:0];

  // Interpolation; the difference wraps so 0x8000 ends still pass through.
  always_comb begin
    logic [15:0] lo;
    logic [15:0] diff;
    logic signed [27:0] prod;
    lo = tbl_r[seg];
    diff = tbl_r[6'(seg) + 6'd1] - lo;
    prod = 28'(signed'(diff)) * 28'(signed'({1'b0, frac}));
    lin_nxt = lo + prod[26:11];
  end

  // Linearized result and the completion pulse.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lin_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= (st_r == ST_LIN);
      if (st_r == ST_LIN) begin
        lin_r <= lin_nxt;
      end
    end
  end

  // Read data one cycle after the strobe; components have no address.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        APF_OFF_CTRL: rdata_r <= ctrl_r;
        APF_OFF_CFG: rdata_r <= cfg_r;
        APF_OFF_STATUS: rdata_r <= 16'(lost_r) << APF_STATUS_LOST_BIT;
        APF_OFF_RAW: rdata_r <= raw_r;
        APF_OFF_MAG: rdata_r <= mag_r;
        APF_OFF_LIN: rdata_r <= lin_r;
        default: rdata_r <= 16'h0000;
      endcase
    end
  end

  assign reg_rdata_out = rdata_r;
  assign busy_out = (st_r != ST_IDLE);
  assign meas_done_out = done_r;
  assign field_lost_flag_out = lost_r;
  assign linearized_angle_out = lin_r;

  // Checks, next to the logic they guard.
  sequence s_accept;
    meas_valid_in && st_r == ST_IDLE;
  endsequence

  sequence s_finish;
    ##[1:20] st_r == ST_LIN ##1 done_r;
  endsequence

  property p_meas_flow;
    @(posedge ref_clk_in) disable iff (!rst_n)
      s_accept |-> s_finish;
  endproperty
  a_meas_flow: assert property (p_meas_flow)
    else $error("measurement did not finish in time");

  property p_cfg_zero;
    @(posedge ref_clk_in) disable iff (!rst_n)
      cfg_r[15:11] == 5'd0;
  endproperty
  a_cfg_zero: assert property (p_cfg_zero)
    else $error("reserved config bits not zero");

  property p_lost_set;
    @(posedge ref_clk_in) disable iff (!rst_n)
      cordic_done && cordic_mag[13:6] < cfg_r[7:0] |=> field_lost_flag_out;
  endproperty
  a_lost_set: assert property (p_lost_set)
    else $error("lost flag not set below limit");

  property p_lost_hold;
    @(posedge ref_clk_in) disable iff (!rst_n)
      cordic_done && lost_r && cordic_mag[15:14] == 2'd0 &&
      cordic_mag[13:0] <= clear_level |=> lost_r;
  endproperty
  a_lost_hold: assert property (p_lost_hold)
    else $error("lost flag cleared inside band");

  property p_lost_clear;
    @(posedge ref_clk_in) disable iff (!rst_n)
      cordic_done && cordic_mag[13:0] > clear_level &&
      cordic_mag[13:6] >= cfg_r[7:0] |=> !lost_r;
  endproperty
  a_lost_clear: assert property (p_lost_clear)
    else $error("lost flag kept above band");

  property p_raw_std;
    @(posedge ref_clk_in) disable iff (!rst_n)
      cordic_done && !(ext_on && grad_on) |=>
        raw_r == $past(cordic_angle);
  endproperty
  a_raw_std: assert property (p_raw_std)
    else $error("standard raw angle altered");

  property p_ext_side;
    @(posedge ref_clk_in) disable iff (!rst_n)
      cordic_done && ext_on && grad_on && outer && cordic_angle[15] |=>
        !raw_r[15] && raw_r >= 16'h5000;
  endproperty
  a_ext_side: assert property (p_ext_side)
    else $error("extended angle not past half turn");

  property p_lin_grid;
    @(posedge ref_clk_in) disable iff (!rst_n)
      st_r == ST_LIN && frac == 11'd0 |=>
        lin_r == $past(tbl_r[seg]);
  endproperty
  a_lin_grid: assert property (p_lin_grid)
    else $error("linear angle off table at base point");
endmodule

/* File: rtl/apf_pkg.sv */
// Package with register map, field layout and timing constants.
package apf_pkg;
  // Register offsets on the serial register port.
  localparam logic [15:0] APF_OFF_CTRL = 16'h000b;
  localparam logic [15:0] APF_OFF_CFG = 16'h0010;
  localparam logic [15:0] APF_OFF_STATUS = 16'h0107;
  localparam logic [15:0] APF_OFF_RAW = 16'h0120;
  localparam logic [15:0] APF_OFF_MAG = 16'h0121;
  localparam logic [15:0] APF_OFF_LIN = 16'h0122;
  // Field positions.
  localparam int APF_CTRL_EXT_BIT = 0;
  localparam int APF_CTRL_GRAD_BIT = 1;
  localparam logic [15:0] APF_CTRL_MASK = 16'h0003;
  localparam logic [15:0] APF_CFG_MASK = 16'h07ff;
  localparam int APF_STATUS_LOST_BIT = 0;
  // Values after reset.
  localparam logic [15:0] APF_CTRL_RESET = 16'h0000;
  localparam logic [15:0] APF_CFG_RESET = 16'h0103;
  // Table layout: 33 points, 2048 codes apart, in non-volatile words.
  localparam int APF_TBL_N = 33;
  localparam int APF_TBL_STEP = 2048;
  localparam logic [7:0] APF_NVM_TOP = 8'h5f;
  localparam logic [7:0] APF_NVM_POS = 8'h60;
  localparam logic [7:0] APF_NVM_NEG = 8'h70;
  localparam logic [7:0] APF_NVM_END = 8'h7f;
  // CORDIC iteration count, one cycle each.
  localparam int APF_CORDIC_ITER = 16;

  // One measurement: first and second field component of two pixels.
  typedef struct packed {
    logic signed [15:0] bi0;
    logic signed [15:0] bj0;
    logic signed [15:0] bi1;
    logic signed [15:0] bj1;
  } apf_meas_t;

  // One register access from the serial port logic.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } apf_reg_req_t;
endpackage

/* File: rtl/apf_cordic.sv */
// Iterative vectoring CORDIC giving angle and magnitude of a vector.
module apf_cordic #(
  parameter int ITER = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic signed [16:0] x_in,
  input wire logic signed [16:0] y_in,
  output logic done_out,
  output logic [15:0] angle_out,
  output logic [15:0] magnitude_out
);
  import apf_pkg::*;

  // Elaboration check: the arctangent table holds 16 entries.
  if (ITER < 1 || ITER > 16) begin : g_bad_iter
    $error("apf_cordic: ITER must lie in 1..16");
  end

  // Six fraction bits keep weak vectors from losing angle precision.
  localparam int FRAC = 6;

  logic signed [25:0] x_r;
  logic signed [25:0] y_r;
  logic [15:0] z_r;
  logic [4:0] step_r;
  logic run_r;

  // Arctangent of 2^-i, with a half turn equal to 16'h8000.
  function automatic logic [15:0] atan_lut(input logic [4:0] i);
    case (i)
      5'd0: atan_lut = 16'h2000;
      5'd1: atan_lut = 16'h12e4;
      5'd2: atan_lut = 16'h09fb;
      5'd3: atan_lut = 16'h0511;
      5'd4: atan_lut = 16'h028b;
      5'd5: atan_lut = 16'h0146;
      5'd6: atan_lut = 16'h00a3;
      5'd7: atan_lut = 16'h0051;
      5'd8: atan_lut = 16'h0029;
      5'd9: atan_lut = 16'h0014;
      5'd10: atan_lut = 16'h000a;
      5'd11: atan_lut = 16'h0005;
      5'd12: atan_lut = 16'h0003;
      5'd13: atan_lut = 16'h0001;
      5'd14: atan_lut = 16'h0001;
      default: atan_lut = 16'h0000;
    endcase
  endfunction

  // Pre-rotation folds the left half plane so the loop always converges.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      x_r <= '0;
      y_r <= '0;
      z_r <= '0;
      step_r <= '0;
      run_r <= 1'b0;
    end else if (start_in) begin
      x_r <= x_in[16] ? -(26'(x_in) <<< FRAC) : 26'(x_in) <<< FRAC;
      y_r <= x_in[16] ? -(26'(y_in) <<< FRAC) : 26'(y_in) <<< FRAC;
      z_r <= x_in[16] ? 16'h8000 : 16'h0000;
      step_r <= '0;
      run_r <= 1'b1;
    end else if (run_r) begin
      if (!y_r[25]) begin
        x_r <= x_r + (y_r >>> step_r);
        y_r <= y_r - (x_r >>> step_r);
        z_r <= z_r + atan_lut(step_r);
      end else begin
        x_r <= x_r - (y_r >>> step_r);
        y_r <= y_r + (x_r >>> step_r);
        z_r <= z_r - atan_lut(step_r);
      end
      step_r <= step_r + 5'd1;
      run_r <= (32'(step_r) != ITER - 1);
    end
  end

  // Done is a single pulse in the cycle after the last step.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= run_r && (32'(step_r) == ITER - 1);
    end
  end

  // The magnitude keeps the CORDIC gain, drops the fraction bits and
  // saturates at 16 bits.
  assign angle_out = z_r;
  assign magnitude_out = (x_r > 26'sh03fffff) ? 16'hffff : x_r[21:6];
endmodule

/* File: verif/test_apf_angle_postprocess.sv */
// Self-checking bench for the angle post-processing and field-lost block.
module test_apf_angle_postprocess;
  timeunit 1ns;
  timeprecision 1ns;
  import apf_pkg::*;
  localparam int ITER_T = 16;
  logic ref_clk_in;
  logic resetn_in;
  logic meas_valid_in;
  apf_meas_t meas;
  apf_reg_req_t req;
  logic [15:0] reg_rdata_out;
  logic nvm_wr_in;
  logic [7:0] nvm_addr_in;
  logic [15:0] nvm_wdata_in;
  logic busy_out;
  logic meas_done_out;
  logic field_lost_flag_out;
  logic [15:0] linearized_angle_out;
  int fails;
  int n_checks;
  int tbl[33];
  int flag_m;
  int cfg_m;
  int ext_m;
  logic [31:0] xs;

  apf_angle_postprocess #(.ITER(ITER_T)) i_apf_angle_postprocess (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .meas_valid_in(meas_valid_in),
    .meas_in(meas),
    .reg_req_in(req),
    .reg_rdata_out(reg_rdata_out),
    .nvm_wr_in(nvm_wr_in),
    .nvm_addr_in(nvm_addr_in),
    .nvm_wdata_in(nvm_wdata_in),
    .busy_out(busy_out),
    .meas_done_out(meas_done_out),
    .field_lost_flag_out(field_lost_flag_out),
    .linearized_angle_out(linearized_angle_out)
  );

  // Free-running 25 MHz clock.
  always #20 ref_clk_in = ~ref_clk_in;

  // Xorshift source; a fixed start keeps every run identical.
  function automatic logic [31:0] rnd();
    xs = xs ^ (xs << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
    return xs;
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Tolerant compare on a circular 16-bit code, for CORDIC rounding.
  task automatic near(input string nm, input int e, input logic [15:0] g,
                      input int tol);
    int d;
    d = (int'(g) - e) & 32'hffff;
    if (d > 32767) d = d - 65536;
    n_checks++;
    if ((^g === 1'bx) || d > tol || d < -tol) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e[15:0], g);
    end
  endtask

  function automatic int exp_ang(input int x, input int y);
    real a;
    a = $atan2(real'(y), real'(x));
    return int'($floor(a / 3.14159265358979 * 32768.0 + 0.5)) & 32'hffff;
  endfunction

  // Expected raw code: mode 1 scales, mode 2 also unwraps past half a turn.
  function automatic int exp_raw(input int x, input int y);
    int a;
    a = exp_ang(x, y);
    if (ext_m == 0) return a;
    if (a > 32767) a = a - 65536;
    if (ext_m == 2) a = (a < 0) ? a + 65536 : a - 65536;
    a = (a * 5) >>> 3;
    if (a > 32767) a = 32767;
    if (a < -32768) a = -32768;
    return a & 32'hffff;
  endfunction

  // Interpolation model; the difference wraps so a 0x8000 end passes.
  function automatic int model_lin(input logic [15:0] raw);
    int rs;
    int idx;
    int lo;
    int d;
    rs = int'($signed(raw));
    idx = rs >>> 11;
    lo = tbl[idx + 16];
    d = (tbl[idx + 17] - lo) & 32'hffff;
    if (d > 32767) d = d - 65536;
    return (lo + ((d * int'(raw & 16'h07ff)) >>> 11)) & 32'hffff;
  endfunction

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk_in);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge ref_clk_in);
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge ref_clk_in);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge ref_clk_in);
    req.rd = 1'b0;
    d = reg_rdata_out;
  endtask

  // Table point k goes to the word the layout assigns to that index.
  task automatic nvm(input int k, input int v);
    @(negedge ref_clk_in);
    nvm_wr_in = 1'b1;
    nvm_wdata_in = v[15:0];
    if (k == 16) nvm_addr_in = APF_NVM_TOP;
    else if (k >= 0) nvm_addr_in = APF_NVM_POS + 8'(k);
    else nvm_addr_in = APF_NVM_NEG + 8'(k + 16);
    tbl[k + 16] = v & 32'hffff;
    @(negedge ref_clk_in);
    nvm_wr_in = 1'b0;
  endtask

  task automatic rst_dut();
    resetn_in = 1'b0;
    repeat (20) @(negedge ref_clk_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    flag_m = 0;
    cfg_m = 32'h0103;
    ext_m = 0;
    for (int k = -16; k <= 16; k++) tbl[k + 16] = (k * 2048) & 32'hffff;
  endtask

  // One measurement; poke offers a second one while busy, to be dropped.
  task automatic run(input int x0, input int y0, input int x1,
                     input int y1, input bit poke);
    int n;
    @(negedge ref_clk_in);
    meas = {16'(x0), 16'(y0), 16'(x1), 16'(y1)};
    meas_valid_in = 1'b1;
    @(negedge ref_clk_in);
    meas_valid_in = 1'b0;
    chk("busy_out", 16'h0001, {15'h0, busy_out});
    n = 1;
    while (meas_done_out !== 1'b1 && n < 60) begin
      @(negedge ref_clk_in);
      n++;
      meas_valid_in = poke && n == 4;
      if (poke && n == 4) meas.bi0 = ~meas.bi0;
    end
    if (n >= 60) begin
      fails++;
      $display("[ERR] meas_done_out expected 1 seen 0");
      final_report();
    end
    chk("done_cycle", 16'(ITER_T + 3), 16'(n));
  endtask

  // Reads all results and compares them with the bench model.
  task automatic res(input int x, input int y, input bit ang);
    logic [15:0] raw;
    logic [15:0] mg;
    logic [15:0] ln;
    logic [15:0] st;
    int m;
    int lim;
    m = int'(1.6467602 * $sqrt(real'(x * x + y * y)));
    lim = cfg_m & 255;
    if (((m >> 6) & 255) < lim) flag_m = 1;
    else if (m >= 16384) flag_m = 0;
    else if (m > lim * 64 + ((16 * lim) >> ((cfg_m >> 8) & 7))) flag_m = 0;
    rd(APF_OFF_RAW, raw);
    if (ang) near("raw_angle", exp_raw(x, y), raw, 16);
    rd(APF_OFF_MAG, mg);
    near("magnitude", m, mg, 8);
    rd(APF_OFF_LIN, ln);
    chk("lin_reg", 16'(model_lin(raw)), ln);
    chk("lin_port", ln, linearized_angle_out);
    chk("lost_port", 16'(flag_m), {15'h0, field_lost_flag_out});
    rd(APF_OFF_STATUS, st);
    chk("lost_status", 16'(flag_m), {15'h0, st[APF_STATUS_LOST_BIT]});
  endtask

  // Field strengths around the limit, with the band on both sides.
  task automatic lost_seq(input int r0, input int r1, input int r2,
                          input int r3);
    int rs[4];
    rs = '{r0, r1, r2, r3};
    foreach (rs[i]) begin
      run(rs[i], 0, 0, 0, 1'b0);
      res(rs[i], 0, 1'b1);
    end
  endtask

  initial begin
    logic [15:0] d;
    logic [31:0] v;
    int x;
    int y;
    ref_clk_in = 1'b0;
    meas_valid_in = 1'b0;
    meas = '0;
    req = '0;
    nvm_wr_in = 1'b0;
    nvm_addr_in = 8'h00;
    nvm_wdata_in = 16'h0000;
    fails = 0;
    n_checks = 0;
    xs = 32'h0000_0020;
    rst_dut();
    // Reset values, masking of config and control, read-only status.
    rd(APF_OFF_CTRL, d);
    chk("ctrl_reset", APF_CTRL_RESET, d);
    rd(APF_OFF_CFG, d);
    chk("cfg_reset", 16'h0103, d);
    rd(16'h0055, d);
    chk("unmapped", 16'h0000, d);
    wr(APF_OFF_CFG, 16'hffff);
    rd(APF_OFF_CFG, d);
    chk("cfg_mask", 16'h07ff, d);
    wr(APF_OFF_CTRL, 16'hffff);
    rd(APF_OFF_CTRL, d);
    chk("ctrl_mask", 16'h0003, d);
    wr(APF_OFF_CTRL, 16'h0000);
    wr(APF_OFF_CFG, 16'h0103);
    wr(APF_OFF_STATUS, 16'hffff);
    rd(APF_OFF_STATUS, d);
    chk("status_ro", 16'h0000, d);
    // Factory table passes the raw angle through; includes half a turn.
    run(-2000, 0, 0, 0, 1'b0);
    res(-2000, 0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      x = int'($signed(v[12:0]));
      y = int'($signed(v[25:13]));
      // Short vectors are pushed out so the angle is well defined.
      if (x * x + y * y < 16000000) x = (x < 0) ? x - 4096 : x + 4096;
      run(x, y, -x, y, i == 0);
      res(x, y, 1'b1);
    end
    // Distinct points everywhere expose a wrong word order or spacing.
    for (int k = -16; k <= 16; k++) begin
      v = rnd();
      nvm(k, k * 2048 + int'(v[9:0]) - 512);
    end
    // Rotary end points, as a table writer must store them.
    nvm(-16, 32'h8000);
    nvm(16, 32'hffff);
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      x = int'($signed(v[12:0]));
      y = int'($signed(v[25:13]));
      if (x * x + y * y < 16000000) x = (x < 0) ? x - 4096 : x + 4096;
      run(x, y, 7, -3, 1'b0);
      res(x, y, 1'b1);
    end
    lost_seq(2000, 60, 124, 2000);
    lost_seq(124, 60, 2000, 124);
    wr(APF_OFF_CFG, 16'h0310);
    cfg_m = 32'h0310;
    lost_seq(600, 632, 700, 632);
    // Gradient mode takes the pixel difference.
    wr(APF_OFF_CTRL, 16'h0002);
    run(500, 300, -3500, -4200, 1'b0);
    res(-4000, -4500, 1'b1);
    // Extension alone leaves the standard angle scale.
    wr(APF_OFF_CTRL, 16'h0001);
    run(-900, 1300, 5, 5, 1'b0);
    res(-900, 1300, 1'b1);
    // Both bits: a stronger far pixel unwraps past the half turn.
    wr(APF_OFF_CTRL, 16'h0003);
    ext_m = 2;
    run(400, 0, -3600, -1200, 1'b0);
    res(-4000, -1200, 1'b1);
    ext_m = 1;
    run(-3600, 1200, 400, 0, 1'b0);
    res(4000, -1200, 1'b1);
    // A second reset restores config and the pass-through table.
    rst_dut();
    rd(APF_OFF_CFG, d);
    chk("cfg_rereset", 16'h0103, d);
    run(1500, -1100, 0, 0, 1'b0);
    res(1500, -1100, 1'b1);
    final_report();
  end
endmodule
